// >>> logic/pmq_params.svh
`ifndef PMQ_PARAMS_SVH
`define PMQ_PARAMS_SVH

// Register byte offsets
`define PMQ_CONTROL_ADDR 8'h00
`define PMQ_ENTRY_WRITE_ADDR 8'h04
`define PMQ_OLDEST_ENTRY_ADDR 8'h08
`define PMQ_MATCH_BIAS_ADDR 8'h0C
`define PMQ_FILL_LEVEL_ADDR 8'h10
`define PMQ_CAPACITY_LIMIT_ADDR 8'h14
`define PMQ_STATUS_ADDR 8'h18
`define PMQ_MATCH_TARGET_ADDR 8'h1C
`define PMQ_IRQ_STATUS_ADDR 8'h20
`define PMQ_IRQ_MASK_ADDR 8'h24

// Control register fields
`define PMQ_CTL_MATCH_ENABLE 0
`define PMQ_CTL_SOURCE_LO 1
`define PMQ_CTL_SOURCE_HI 2
`define PMQ_CTL_FLUSH_ALL 3
`define PMQ_CTL_POP 4

// Status register fields
`define PMQ_ST_NO_ENTRIES 0
`define PMQ_ST_FILL_REACHED 1
`define PMQ_ST_CAP_EXCEEDED 2
`define PMQ_ST_MATCH_EVENT 3
`define PMQ_ST_COUNT_LO 8

// Interrupt status and mask fields
`define PMQ_IRQ_WIDTH 4
`define PMQ_IRQ_MATCH 0
`define PMQ_IRQ_REFUSED 1
`define PMQ_IRQ_FILL 2
`define PMQ_IRQ_EMPTY 3

// Reset values
`define PMQ_FILL_LEVEL_RESET 8
`define PMQ_MATCH_BIAS_RESET 32'h0000_0000
`define PMQ_IRQ_MASK_RESET 4'h0

`endif

// >>> logic/pmq_pkg.sv
package pmq_pkg;

   // Position source compared with the match target
   typedef enum logic [1:0] {
      src_motor_feedback,
      src_master_feedback,
      src_motor_command
   } pos_source_type;

endpackage : pmq_pkg

// >>> logic/position_match_queue.sv
// Summary of operation
// - Holds up to capacity_limit entries; an attempt beyond flags overflow.
// - A write to entry_write appends the value with the current match_bias.
// - No value is appended while capacity_exceeded is set.
// - oldest_entry always shows the oldest stored entry.
// - match_target is the oldest entry plus its match_bias.
// - match_target changes only on first push into empty queue or a pop.
// - fill_threshold_reached is set while count is at or above fill_level.
// - fill_threshold_reached is a flag only, never stops or faults.
// - flush_all throws away every entry and leaves the queue empty.
// - With match_enable low the match event never sets.
// - With match_enable high and an entry held, source equal to match_target sets the event.
// - The match event stays set until a pop or a flush_all clears it.
// - no_entries_flag is set whenever the queue is empty.
// - no_entries_flag drops on first push and stays low until fully emptied.
// - A pop deletes the oldest stored entry.
// - Source is motor feedback, master feedback or motor command position.
// - capacity_exceeded is set when there is no room for another entry.
`timescale 1ns/10ps
`include "pmq_params.svh"

module position_match_queue #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [WIDTH-1:0] motor_feedback_pos,
   input wire logic [WIDTH-1:0] master_feedback_pos,
   input wire logic [WIDTH-1:0] motor_command_pos,
   output logic position_match_event,
   output logic no_entries_flag,
   output logic fill_threshold_reached,
   output logic capacity_exceeded,
   output logic irq
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   logic [WIDTH-1:0] entry_mem [DEPTH];
   logic [WIDTH-1:0] target_mem [DEPTH];
   logic [AW-1:0] head;
   logic [AW-1:0] tail;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic [CW-1:0] capacity_limit;
   logic [CW-1:0] fill_level;
   logic [WIDTH-1:0] match_bias;
   logic [WIDTH-1:0] match_target;
   logic match_enable;
   pmq_pkg::pos_source_type source_sel;
   logic [WIDTH-1:0] source_value;
   logic [`PMQ_IRQ_WIDTH-1:0] irq_status;
   logic [`PMQ_IRQ_WIDTH-1:0] irq_mask;
   logic [`PMQ_IRQ_WIDTH-1:0] irq_events;

   logic setup;
   logic access;
   logic wr_en;
   logic addr_ok;
   logic [31:0] rd_value;
   logic push_req;
   logic push_ok;
   logic pop_ok;
   logic pop_req;
   logic flush_req;
   logic [AW-1:0] head_next_idx;
   logic [AW-1:0] tail_next_idx;
   logic no_room;

   // APB decode
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign wr_en = access & pwrite & ~pslverr;

   always_comb begin
      addr_ok = 1'b1;
      rd_value = 32'h0000_0000;
      case (paddr[7:0])
         `PMQ_CONTROL_ADDR: begin
            rd_value[`PMQ_CTL_MATCH_ENABLE] = match_enable;
            rd_value[`PMQ_CTL_SOURCE_HI:`PMQ_CTL_SOURCE_LO] = source_sel;
         end
         `PMQ_ENTRY_WRITE_ADDR: rd_value = 32'h0000_0000;
         `PMQ_OLDEST_ENTRY_ADDR: rd_value[WIDTH-1:0] = entry_mem[head];
         `PMQ_MATCH_BIAS_ADDR: rd_value[WIDTH-1:0] = match_bias;
         `PMQ_FILL_LEVEL_ADDR: rd_value[CW-1:0] = fill_level;
         `PMQ_CAPACITY_LIMIT_ADDR: rd_value[CW-1:0] = capacity_limit;
         `PMQ_STATUS_ADDR: begin
            rd_value[`PMQ_ST_NO_ENTRIES] = no_entries_flag;
            rd_value[`PMQ_ST_FILL_REACHED] = fill_threshold_reached;
            rd_value[`PMQ_ST_CAP_EXCEEDED] = capacity_exceeded;
            rd_value[`PMQ_ST_MATCH_EVENT] = position_match_event;
            rd_value[`PMQ_ST_COUNT_LO +: CW] = count;
         end
         `PMQ_MATCH_TARGET_ADDR: rd_value[WIDTH-1:0] = match_target;
         `PMQ_IRQ_STATUS_ADDR: begin
            rd_value[`PMQ_IRQ_WIDTH-1:0] = irq_status;
         end
         `PMQ_IRQ_MASK_ADDR: rd_value[`PMQ_IRQ_WIDTH-1:0] = irq_mask;
         default: addr_ok = 1'b0;
      endcase
      if (paddr[31:8] != 24'h00_0000) begin
         addr_ok = 1'b0;
         rd_value = 32'h0000_0000;
      end
   end

   // One wait-free access phase: answer is prepared during setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         pready <= 1'b1;
         pslverr <= ~addr_ok;
         prdata <= pwrite ? 32'h0000_0000 : rd_value;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Software controls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_enable <= 1'b0;
         source_sel <= pmq_pkg::src_motor_feedback;
         match_bias <= WIDTH'(`PMQ_MATCH_BIAS_RESET);
         fill_level <= CW'(`PMQ_FILL_LEVEL_RESET);
         capacity_limit <= DEPTH_C;
         irq_mask <= `PMQ_IRQ_MASK_RESET;
      end else if (wr_en) begin
         case (paddr[7:0])
            `PMQ_CONTROL_ADDR: begin
               match_enable <= pwdata[`PMQ_CTL_MATCH_ENABLE];
               case (pwdata[`PMQ_CTL_SOURCE_HI:`PMQ_CTL_SOURCE_LO])
                  2'h1: source_sel <= pmq_pkg::src_master_feedback;
                  2'h2: source_sel <= pmq_pkg::src_motor_command;
                  default: source_sel <= pmq_pkg::src_motor_feedback;
               endcase
            end
            `PMQ_MATCH_BIAS_ADDR: match_bias <= pwdata[WIDTH-1:0];
            `PMQ_FILL_LEVEL_ADDR: fill_level <= pwdata[CW-1:0];
            `PMQ_CAPACITY_LIMIT_ADDR: begin
               // Never more than the storage that exists
               if (pwdata > 32'(DEPTH)) begin
                  capacity_limit <= DEPTH_C;
               end else begin
                  capacity_limit <= pwdata[CW-1:0];
               end
            end
            `PMQ_IRQ_MASK_ADDR: begin
               irq_mask <= pwdata[`PMQ_IRQ_WIDTH-1:0];
            end
            default: ;
         endcase
      end
   end

   // Queue commands
   assign push_req = wr_en && (paddr[7:0] == `PMQ_ENTRY_WRITE_ADDR);
   assign flush_req = wr_en && (paddr[7:0] == `PMQ_CONTROL_ADDR) &&
                      pwdata[`PMQ_CTL_FLUSH_ALL];
   assign pop_req = wr_en && (paddr[7:0] == `PMQ_CONTROL_ADDR) &&
                    pwdata[`PMQ_CTL_POP];
   assign no_room = (count >= capacity_limit);
   assign push_ok = push_req & ~no_room;
   assign pop_ok = pop_req & ~flush_req & (count != '0);
   assign head_next_idx = (head == LAST_IDX) ? '0 : head + 1'b1;
   assign tail_next_idx = (tail == LAST_IDX) ? '0 : tail + 1'b1;

   always_comb begin
      next_count = count;
      if (flush_req) begin
         next_count = '0;
      end else if (push_ok) begin
         next_count = count + 1'b1;
      end else if (pop_ok) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (push_ok) begin
         entry_mem[tail] <= pwdata[WIDTH-1:0];
         target_mem[tail] <= pwdata[WIDTH-1:0] + match_bias;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         head <= '0;
         tail <= '0;
         count <= '0;
      end else begin
         count <= next_count;
         if (flush_req) begin
            head <= '0;
            tail <= '0;
         end else begin
            if (push_ok) begin
               tail <= tail_next_idx;
            end
            if (pop_ok) begin
               head <= head_next_idx;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_target <= '0;
      end else if (!flush_req) begin
         if (push_ok && count == '0) begin
            match_target <= pwdata[WIDTH-1:0] + match_bias;
         end else if (pop_ok && count > CW'(1)) begin
            match_target <= target_mem[head_next_idx];
         end
      end
   end

   always_comb begin
      case (source_sel)
         pmq_pkg::src_master_feedback: source_value = master_feedback_pos;
         pmq_pkg::src_motor_command: source_value = motor_command_pos;
         default: source_value = motor_feedback_pos;
      endcase
   end

   // Compare is only meaningful while an entry is held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         position_match_event <= 1'b0;
      end else if (pop_req || flush_req) begin
         position_match_event <= 1'b0;
      end else if (match_enable && count != '0 &&
                   source_value == match_target) begin
         position_match_event <= 1'b1;
      end
   end

   // Flags follow the count as it leaves this edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         no_entries_flag <= 1'b1;
         fill_threshold_reached <= 1'b0;
         capacity_exceeded <= 1'b0;
      end else begin
         no_entries_flag <= (next_count == '0);
         fill_threshold_reached <= (next_count >= fill_level);
         capacity_exceeded <= (next_count >= capacity_limit);
      end
   end

   // Interrupt events: rising flags and refused appends
   always_comb begin
      irq_events = '0;
      irq_events[`PMQ_IRQ_MATCH] = ~position_match_event &&
         !(pop_req || flush_req) && match_enable && count != '0 &&
         source_value == match_target;
      irq_events[`PMQ_IRQ_REFUSED] = push_req & no_room;
      irq_events[`PMQ_IRQ_FILL] = ~fill_threshold_reached &&
         (next_count >= fill_level);
      irq_events[`PMQ_IRQ_EMPTY] = ~no_entries_flag && (next_count == '0);
   end

   // Set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
      end else if (wr_en && paddr[7:0] == `PMQ_IRQ_STATUS_ADDR) begin
         irq_status <= (irq_status & ~pwdata[`PMQ_IRQ_WIDTH-1:0]) |
                       irq_events;
      end else begin
         irq_status <= irq_status | irq_events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_status | irq_events) & irq_mask);
      end
   end

endmodule : position_match_queue

// >>> tb/motion_position_model.sv
`timescale 1ns/10ps
module motion_position_model (
   input wire logic pclk,
   input wire logic [1:0] sel,
   input wire logic hit,
   input wire logic [31:0] value,
   output logic [31:0] motor_feedback_pos,
   output logic [31:0] master_feedback_pos,
   output logic [31:0] motor_command_pos
);
   // Sources not aimed at sit on the inverse so they never match by chance
   always_ff @(posedge pclk) begin
      motor_feedback_pos <= (hit && sel == 2'h0) ? value : ~value;
      master_feedback_pos <= (hit && sel == 2'h1) ? value : ~value;
      motor_command_pos <= (hit && sel == 2'h2) ? value : ~value;
   end
endmodule : motion_position_model

// >>> tb/pmq_sva.sv
`timescale 1ns/10ps
module pmq_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input logic pready,
   input logic pslverr,
   input logic position_match_event,
   input logic no_entries_flag,
   input logic capacity_exceeded
);
   logic en;
   logic acc;
   logic clr;
   logic push;
   assign acc = psel && penable && pready && pwrite;
   assign clr = acc && paddr[7:0] == 8'h00 && (pwdata[3] || pwdata[4]);
   assign push = acc && paddr[7:0] == 8'h04;
   // Shadow of the compare enable bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en <= 1'b0;
      end else if (acc && paddr[7:0] == 8'h00) begin
         en <= pwdata[0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready;
      pready == $past(psel && !penable);
   endproperty
   a_ready: assert property (p_ready) else $error("bad access cycle");
   property p_err;
      pslverr |-> pready && (paddr[7:0] > 8'h24 || paddr[1:0] != 2'b00 ||
         paddr[31:8] != 24'h00_0000);
   endproperty
   a_err: assert property (p_err) else $error("bad slave error");
   property p_hold;
      position_match_event && !clr |=> position_match_event;
   endproperty
   a_hold: assert property (p_hold) else $error("match lost");
   property p_clear;
      clr |=> !position_match_event;
   endproperty
   a_clear: assert property (p_clear) else $error("match kept");
   property p_off;
      $rose(position_match_event) |-> $past(en);
   endproperty
   a_off: assert property (p_off) else $error("match while off");
   property p_fall;
      $fell(no_entries_flag) |-> $past(push);
   endproperty
   a_fall: assert property (p_fall) else $error("empty fell");
   property p_rise;
      $rose(no_entries_flag) |-> $past(clr);
   endproperty
   a_rise: assert property (p_rise) else $error("empty rose");
   property p_empty;
      no_entries_flag |-> !position_match_event;
   endproperty
   a_empty: assert property (p_empty) else $error("match on empty");
   property p_cap;
      $rose(capacity_exceeded) |-> $past(acc);
   endproperty
   a_cap: assert property (p_cap) else $error("overflow rose");
endmodule : pmq_sva

bind position_match_queue pmq_sva u_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .position_match_event(position_match_event),
   .no_entries_flag(no_entries_flag), .capacity_exceeded(capacity_exceeded));

// >>> tb/position_match_queue_tb.sv
`timescale 1ns/10ps
`include "pmq_params.svh"
module position_match_queue_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, hit;
   logic [31:0] paddr, pwdata, prdata, rd, fb, mf, cp, val;
   logic [1:0] sel;
   logic ev, ne, fr, ce, irq;
   logic [31:0] tg [3];
   int err_count, checked, cyc, i, n;

   position_match_queue u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .motor_feedback_pos(fb), .master_feedback_pos(mf),
      .motor_command_pos(cp), .position_match_event(ev),
      .no_entries_flag(ne), .fill_threshold_reached(fr),
      .capacity_exceeded(ce), .irq(irq));
   motion_position_model u_model (.pclk(pclk), .sel(sel), .hit(hit),
      .value(val), .motor_feedback_pos(fb), .master_feedback_pos(mf),
      .motor_command_pos(cp));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         $display("Error at %0t: timeout", $time);
         tally_and_finish();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc

   task t_reset;
      rdc(`PMQ_STATUS_ADDR, 32'h1);
      rdc(`PMQ_FILL_LEVEL_ADDR, `PMQ_FILL_LEVEL_RESET);
      rdc(`PMQ_CAPACITY_LIMIT_ADDR, 32'h10);
      rdc(`PMQ_MATCH_BIAS_ADDR, `PMQ_MATCH_BIAS_RESET);
      rdc(`PMQ_IRQ_MASK_ADDR, 32'h0);
      apb(1'b1, `PMQ_CONTROL_ADDR, 32'h8);
   endtask : t_reset

   task t_fill;
      apb(1'b1, `PMQ_CAPACITY_LIMIT_ADDR, 32'h4);
      apb(1'b1, `PMQ_FILL_LEVEL_ADDR, 32'h3);
      apb(1'b1, `PMQ_MATCH_BIAS_ADDR, 32'hA);
      apb(1'b1, `PMQ_ENTRY_WRITE_ADDR, 32'h5);
      #1 chk(ne, 1'b0);
      apb(1'b1, `PMQ_MATCH_BIAS_ADDR, 32'h14);
      for (i = 6; i <= 8; i++) apb(1'b1, `PMQ_ENTRY_WRITE_ADDR, 32'(i));
      rdc(`PMQ_MATCH_TARGET_ADDR, 32'hF);
      rdc(`PMQ_OLDEST_ENTRY_ADDR, 32'h5);
      rdc(`PMQ_STATUS_ADDR, 32'h406);
      apb(1'b1, `PMQ_ENTRY_WRITE_ADDR, 32'h9);
      rdc(`PMQ_STATUS_ADDR, 32'h406);
      chk(ce, 1'b1);
      chk(fr, 1'b1);
      apb(1'b0, `PMQ_IRQ_STATUS_ADDR, 32'h0);
      chk(rd & 32'h2, 32'h2);
      apb(1'b1, `PMQ_CONTROL_ADDR, 32'h10);
      rdc(`PMQ_OLDEST_ENTRY_ADDR, 32'h6);
      rdc(`PMQ_MATCH_TARGET_ADDR, 32'h1A);
      apb(1'b1, `PMQ_CONTROL_ADDR, 32'h10);
      rdc(`PMQ_STATUS_ADDR, 32'h200);
      chk(fr, 1'b0);
      chk(ce, 1'b0);
      apb(1'b1, `PMQ_ENTRY_WRITE_ADDR, 32'hA);
   endtask : t_fill

   task t_match;
      logic [31:0] c;
      tg = '{32'h1B, 32'h1C, 32'h1E};
      for (i = 0; i < 3; i++) begin
         c = 32'(i) << 1;
         apb(1'b1, `PMQ_IRQ_MASK_ADDR, {31'h0, i != 2});
         apb(1'b1, `PMQ_CONTROL_ADDR, c);
         sel <= 2'(i);
         hit <= 1'b1;
         val <= tg[i];
         repeat (4) @(posedge pclk);
         chk(ev, 1'b0);
         sel <= 2'((i + 1) % 3);
         apb(1'b1, `PMQ_CONTROL_ADDR, c | 32'h1);
         repeat (4) @(posedge pclk);
         chk(ev, 1'b0);
         sel <= 2'(i);
         n = 0;
         while (ev !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
         end
         repeat (2) @(posedge pclk);
         chk(ev, 1'b1);
         chk(irq, i != 2);
         hit <= 1'b0;
         repeat (3) @(posedge pclk);
         chk(ev, 1'b1);
         apb(1'b1, `PMQ_IRQ_STATUS_ADDR, 32'h1);
         repeat (2) @(posedge pclk);
         chk(irq, 1'b0);
         apb(1'b1, `PMQ_CONTROL_ADDR, c | 32'h11);
         #1 chk(ev, 1'b0);
      end
      chk(ne, 1'b1);
      apb(1'b1, `PMQ_CONTROL_ADDR, 32'h10);
      rdc(`PMQ_STATUS_ADDR, 32'h1);
      rdc(`PMQ_MATCH_TARGET_ADDR, 32'h1E);
      rdc(`PMQ_IRQ_STATUS_ADDR, 32'hE);
   endtask : t_match

   task t_flush;
      apb(1'b1, `PMQ_ENTRY_WRITE_ADDR, 32'h1);
      apb(1'b1, `PMQ_ENTRY_WRITE_ADDR, 32'h2);
      apb(1'b1, `PMQ_CONTROL_ADDR, 32'h8);
      rdc(`PMQ_STATUS_ADDR, 32'h1);
      apb(1'b1, `PMQ_CAPACITY_LIMIT_ADDR, 32'h20);
      rdc(`PMQ_CAPACITY_LIMIT_ADDR, 32'h10);
      apb(1'b0, 8'h40, 32'h0);
      chk(perr, 1'b1);
      chk(rd, 32'h0);
   endtask : t_flush

   task tally_and_finish;
      $display("Checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      sel = 2'h0;
      hit = 1'b0;
      val = 32'h0;
      cyc = 0;
      err_count = 0;
      checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_fill();
      t_match();
      t_flush();
      tally_and_finish();
   end
endmodule : position_match_queue_tb
